/* File: rtl/fcm_pkg.sv */
package fcm_pkg;

  // ----------------------------------------------------------------------
  // message layout
  // ----------------------------------------------------------------------
  localparam int unsigned MSG_W = 27;
  localparam int unsigned PAY_W = 26;
  localparam int unsigned READY_BIT = 26;
  localparam logic [3:0] ST_XON = 4'hF;
  localparam logic [3:0] ST_XOFF = 4'h0;
  localparam logic [1:0] TY_UNI = 2'h0;
  localparam logic [1:0] TY_CLS = 2'h1;
  localparam logic [1:0] TY_RSV = 2'h2;
  localparam logic [1:0] TY_IDLE = 2'h3;
  localparam logic [2:0] TY_MC = 3'h4;
  localparam logic [2:0] TY_GLB = 3'h5;
  localparam logic [25:0] IDLE_PAY = 26'h3000000;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ARG = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_CLASS_TX = 8'h0C;
  localparam logic [7:0] OFF_CLASS_RD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [27:0] CLASS_TX_RESET = 28'h000FFFF;
  localparam int unsigned CTRL_EGRESS = 0;
  localparam int unsigned CTRL_QMAP = 1;
  localparam int unsigned CTRL_SUBPORT = 2;
  localparam int unsigned CTRL_INDEP = 3;
  localparam int unsigned CTRL_READY = 4;
  localparam int unsigned CTRL_REFRESH = 5;
  localparam int unsigned CTRL_SEL_LSB = 8;
  localparam int unsigned CMD_XON = 3;
  localparam int unsigned CMD_SP_LSB = 4;
  localparam int unsigned CMD_MSEL = 8;
  localparam int unsigned CTX_MSEL = 20;
  localparam int unsigned CTX_SP_LSB = 24;

  // ----------------------------------------------------------------------
  // message kinds and timing
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    K_UNICAST = 3'h0,
    K_CLASS = 3'h1,
    K_MCAST = 3'h2,
    K_GLOBAL = 3'h3,
    K_UMAP = 3'h4,
    K_MMAP = 3'h5,
    K_IDLE = 3'h6,
    K_RSVD = 3'h7
  } kind_t;

  localparam int unsigned REFRESH_TIME_US = 100;
  localparam int unsigned CLK_FREQ_MHZ = 100;
  localparam int unsigned REFRESH_CYCLES = REFRESH_TIME_US * CLK_FREQ_MHZ;

endpackage

/* File: rtl/fabric_flow_control_message_codec.sv */
// Overview of operation
// - every built or parsed message is 27 bits with one ready bit
// - bit 26 carries the sender ready state, 1 means can accept data
// - unicast queue message: type 00, queue address 23:4, unused bits zero
// - queue status XON is 1111, XOFF 0000, other codes never generated
// - multicast message: type 100, zeros 22:16, subport 15:12, class 11:4
// - subport field zero on transmit and ignored on receive when disabled
// - ingress class message: type 01, subport, 4-bit group, 16-bit bitmap
// - bitmap bit i is class {group,i}, 1 means XON
// - global message type 101 carries an 8-bit shared-space code
// - global code uses 1..8 msb-aligned bits, unused low bits zero
// - queue-map unicast: type 00, 8-bit group 23:16, 16-bit bitmap
// - queue-map multicast: type 01, zeros 23:20, group 19:16, bitmap
// - queue-map mode uses only queue-map formats, type 10 reserved
// - idle sent in every tx slot when not training, no alarm and nothing pending
// - idle message is type 11 with bits 23:0 zero
// - egress class: bit 25 zero, bit 24 selects multicast when independent
// - shared class mode clears bit 24 on transmit, ignores it on receive
// - egress subport zero on transmit, ignored on receive when disabled
// - receiver keeps persistent per-class state, reset XON, class updates only
// - class message sent on class change, optional periodic refresh
// - own and link ready states start deasserted, all class states start XON
// - parity failure drops the message and forces link not ready
`timescale 1ns/1ps
`default_nettype none

module fabric_flow_control_message_codec #(
  parameter logic [19:0] UC_ADDR_MASK = 20'hFFFFF,
  parameter int unsigned GLOBAL_BITS = 8,
  parameter int unsigned REFRESH_CYCLES = fcm_pkg::REFRESH_CYCLES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic tx_slot_in,
  input wire logic training_in,
  input wire logic loss_of_sync_alarm_in,
  output logic [26:0] tx_msg_out,
  output logic tx_valid_out,
  input wire logic [26:0] rx_msg_in,
  input wire logic rx_valid_in,
  input wire logic rx_parity_ok_in,
  output logic link_ready_state_out,
  output logic rx_dec_valid_out,
  output logic [2:0] rx_dec_kind_out,
  output logic [7:0] rx_dec_group_out,
  output logic [19:0] rx_dec_field_out,
  output logic [3:0] rx_dec_subport_out,
  output logic rx_dec_xon_out,
  output logic rx_dec_ready_out,
  output logic rx_dec_reserved_out
);

  localparam logic [7:0] GLOBAL_MASK = 8'(16'hFF00 >> GLOBAL_BITS);

  // ----------------------------------------------------------------------
  // configuration and software state
  // ----------------------------------------------------------------------
  logic [11:0] ctrl;
  logic [23:0] tx_arg;
  logic [27:0] class_tx;
  logic [25:0] cmd_msg;
  logic cmd_pending;
  logic class_due;
  logic [31:0] refresh_cnt;
  logic [15:0] uc_class [16];
  logic [15:0] mc_class [16];

  wire logic egress = ctrl[fcm_pkg::CTRL_EGRESS];
  wire logic qmap = ctrl[fcm_pkg::CTRL_QMAP] & ~egress;
  wire logic sub_en = ctrl[fcm_pkg::CTRL_SUBPORT];
  wire logic indep = ctrl[fcm_pkg::CTRL_INDEP];
  wire logic own_ready = ctrl[fcm_pkg::CTRL_READY];
  wire logic refresh_en = ctrl[fcm_pkg::CTRL_REFRESH];
  wire logic [3:0] rd_sel = ctrl[fcm_pkg::CTRL_SEL_LSB +: 4];

  // ----------------------------------------------------------------------
  // apb decode: no wait state, yet every answer comes from a flop
  // ----------------------------------------------------------------------
  wire logic apb_setup = psel_in & ~penable_in;
  wire logic apb_done = psel_in & penable_in & pready_out;
  wire logic wr_en = apb_done & pwrite_in;
  wire logic hit_ctrl = paddr_in == fcm_pkg::OFF_CTRL;
  wire logic hit_arg = paddr_in == fcm_pkg::OFF_ARG;
  wire logic hit_cmd = paddr_in == fcm_pkg::OFF_CMD;
  wire logic hit_ctx = paddr_in == fcm_pkg::OFF_CLASS_TX;
  wire logic hit_crd = paddr_in == fcm_pkg::OFF_CLASS_RD;
  wire logic hit_sts = paddr_in == fcm_pkg::OFF_STATUS;
  wire logic addr_ok = hit_ctrl | hit_arg | hit_cmd | hit_ctx | hit_crd | hit_sts;
  wire logic [31:0] status_word = {29'h0, class_due, cmd_pending, link_ready_state_out};
  wire logic [31:0] rd_mux = hit_ctrl ? {20'h0, ctrl} :
                             hit_arg ? {8'h0, tx_arg} :
                             hit_ctx ? {4'h0, class_tx} :
                             hit_crd ? {mc_class[rd_sel], uc_class[rd_sel]} :
                             hit_sts ? status_word : 32'h0;

  // ----------------------------------------------------------------------
  // command legality per configuration
  // ----------------------------------------------------------------------
  wire logic [2:0] cmd_kind = pwdata_in[2:0];
  wire logic kind_std = (cmd_kind == fcm_pkg::K_UNICAST) | (cmd_kind == fcm_pkg::K_CLASS) |
                        (cmd_kind == fcm_pkg::K_MCAST) | (cmd_kind == fcm_pkg::K_GLOBAL);
  wire logic kind_map = (cmd_kind == fcm_pkg::K_UMAP) | (cmd_kind == fcm_pkg::K_MMAP);
  // queue-map mode refuses standard formats and vice versa
  wire logic kind_ok = egress ? (cmd_kind == fcm_pkg::K_CLASS) :
                       qmap ? kind_map : kind_std;
  wire logic cmd_refuse = pwrite_in & hit_cmd & (cmd_pending | ~kind_ok);
  wire logic next_err = ~addr_ok | cmd_refuse;
  wire logic cmd_accept = wr_en & hit_cmd & ~pslverr_out;

  // the answer is prepared in setup so the access phase sees it registered
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= apb_setup & next_err;
      prdata_out <= (apb_setup & ~pwrite_in) ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // message builder: fields from the argument register and the command
  // ----------------------------------------------------------------------
  wire logic [3:0] cmd_sp = sub_en ? pwdata_in[fcm_pkg::CMD_SP_LSB +: 4] : 4'h0;
  wire logic [3:0] cmd_st = pwdata_in[fcm_pkg::CMD_XON] ? fcm_pkg::ST_XON : fcm_pkg::ST_XOFF;
  wire logic cmd_m = indep & pwdata_in[fcm_pkg::CMD_MSEL];
  wire logic [19:0] uc_addr = tx_arg[19:0] & UC_ADDR_MASK;
  wire logic [7:0] glb_code = tx_arg[7:0] & GLOBAL_MASK;
  // both queue-map formats carry group and bitmap straight from the argument
  wire logic [25:0] pay_uni = {fcm_pkg::TY_UNI, uc_addr, cmd_st};
  wire logic [25:0] pay_cls = egress ? {1'b0, cmd_m, cmd_sp, tx_arg[19:0]} :
                              {fcm_pkg::TY_CLS, cmd_sp, tx_arg[19:0]};
  wire logic [25:0] pay_mc = {fcm_pkg::TY_MC, 7'h00, cmd_sp, tx_arg[7:0], cmd_st};
  wire logic [25:0] pay_glb = {fcm_pkg::TY_GLB, 15'h0000, glb_code};
  wire logic [25:0] pay_umap = {fcm_pkg::TY_UNI, tx_arg[23:0]};
  wire logic [25:0] pay_mmap = {fcm_pkg::TY_CLS, 4'h0, tx_arg[19:0]};
  wire logic [25:0] pay_cmd = (cmd_kind == fcm_pkg::K_UNICAST) ? pay_uni :
                              (cmd_kind == fcm_pkg::K_CLASS) ? pay_cls :
                              (cmd_kind == fcm_pkg::K_MCAST) ? pay_mc :
                              (cmd_kind == fcm_pkg::K_GLOBAL) ? pay_glb :
                              (cmd_kind == fcm_pkg::K_UMAP) ? pay_umap : pay_mmap;

  // automatic class message from the class transmit register
  wire logic [3:0] ctx_sp = sub_en ? class_tx[fcm_pkg::CTX_SP_LSB +: 4] : 4'h0;
  wire logic ctx_m = indep & class_tx[fcm_pkg::CTX_MSEL];
  wire logic [25:0] pay_auto = egress ? {1'b0, ctx_m, ctx_sp, class_tx[19:0]} :
                               {fcm_pkg::TY_CLS, ctx_sp, class_tx[19:0]};

  // ----------------------------------------------------------------------
  // transmit scheduling
  // ----------------------------------------------------------------------
  wire logic slot_go = tx_slot_in & ~training_in & ~loss_of_sync_alarm_in;
  wire logic send_cmd = slot_go & cmd_pending;
  wire logic send_cls = slot_go & ~cmd_pending & class_due & ~qmap;
  // idle fills every usable slot that nothing else claims
  wire logic [25:0] pay_out = send_cmd ? cmd_msg : send_cls ? pay_auto : fcm_pkg::IDLE_PAY;
  wire logic ctx_write = wr_en & hit_ctx;
  wire logic ctx_change = ctx_write & (pwdata_in[27:0] != class_tx);
  wire logic refresh_hit = refresh_en & (refresh_cnt >= REFRESH_CYCLES - 1);
  // a new request in the sending cycle survives: set wins over clear
  wire logic next_class_due = ((ctx_change | refresh_hit) & ~qmap) | (class_due & ~send_cls);
  wire logic next_cmd_pending = cmd_accept | (cmd_pending & ~send_cmd);

  // software registers; own ready starts deasserted
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= fcm_pkg::CTRL_RESET;
      tx_arg <= 24'h0;
      class_tx <= fcm_pkg::CLASS_TX_RESET;
    end else begin
      if (wr_en & hit_ctrl)
        ctrl <= pwdata_in[11:0];
      if (wr_en & hit_arg)
        tx_arg <= pwdata_in[23:0];
      if (ctx_write)
        class_tx <= pwdata_in[27:0];
    end
  end

  // pending command and class update bookkeeping
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_pending <= 1'b0;
      cmd_msg <= fcm_pkg::IDLE_PAY;
      class_due <= 1'b0;
    end else begin
      cmd_pending <= next_cmd_pending;
      class_due <= next_class_due;
      if (cmd_accept)
        cmd_msg <= pay_cmd;
    end
  end

  // refresh timer recovers lost class messages; restarts on every automatic class send
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      refresh_cnt <= 32'h0;
    end else if (!refresh_en || refresh_hit || send_cls) begin
      refresh_cnt <= 32'h0;
    end else begin
      refresh_cnt <= refresh_cnt + 32'h1;
    end
  end

  // outgoing message register, ready bit on top
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_valid_out <= 1'b0;
      tx_msg_out <= {1'b0, fcm_pkg::IDLE_PAY};
    end else begin
      tx_valid_out <= slot_go;
      tx_msg_out <= {own_ready, pay_out};
    end
  end

  // ----------------------------------------------------------------------
  // receive decode
  // ----------------------------------------------------------------------
  wire logic [1:0] rx_t2 = rx_msg_in[25:24];
  wire logic rx_accept = rx_valid_in & rx_parity_ok_in;
  wire logic [2:0] rx_kind = egress ? (!rx_msg_in[25] ? fcm_pkg::K_CLASS :
                                  (rx_t2 == fcm_pkg::TY_IDLE) ? fcm_pkg::K_IDLE :
                                  fcm_pkg::K_RSVD) :
                        qmap ? ((rx_t2 == fcm_pkg::TY_UNI) ? fcm_pkg::K_UMAP :
                                (rx_t2 == fcm_pkg::TY_CLS) ? fcm_pkg::K_MMAP :
                                (rx_t2 == fcm_pkg::TY_IDLE) ? fcm_pkg::K_IDLE :
                                fcm_pkg::K_RSVD) :
                        ((rx_t2 == fcm_pkg::TY_UNI) ? fcm_pkg::K_UNICAST :
                         (rx_t2 == fcm_pkg::TY_CLS) ? fcm_pkg::K_CLASS :
                         (rx_t2 == fcm_pkg::TY_IDLE) ? fcm_pkg::K_IDLE :
                         rx_msg_in[23] ? fcm_pkg::K_GLOBAL : fcm_pkg::K_MCAST);
  wire logic rx_has_st = (rx_kind == fcm_pkg::K_UNICAST) | (rx_kind == fcm_pkg::K_MCAST);
  wire logic [3:0] rx_st = rx_msg_in[3:0];
  wire logic rx_st_bad = rx_has_st & (rx_st != fcm_pkg::ST_XON) & (rx_st != fcm_pkg::ST_XOFF);
  wire logic rx_rsv = (rx_kind == fcm_pkg::K_RSVD) | rx_st_bad;
  // in shared mode the multicast select bit is disregarded
  wire logic rx_m = egress & indep & rx_msg_in[24];
  wire logic cls_upd = rx_accept & (rx_kind == fcm_pkg::K_CLASS) & ~rx_rsv;
  wire logic uc_upd = cls_upd & ~rx_m;
  wire logic mc_upd = cls_upd & egress & (rx_m | ~indep);
  wire logic [3:0] rx_grp = rx_msg_in[19:16];
  wire logic [7:0] rx_group = (rx_kind == fcm_pkg::K_UMAP) ? rx_msg_in[23:16] :
                              ((rx_kind == fcm_pkg::K_CLASS) | (rx_kind == fcm_pkg::K_MMAP)) ?
                              {4'h0, rx_grp} : 8'h00;
  wire logic [19:0] rx_field = (rx_kind == fcm_pkg::K_UNICAST) ? rx_msg_in[23:4] :
                               (rx_kind == fcm_pkg::K_MCAST) ? {12'h000, rx_msg_in[11:4]} :
                               (rx_kind == fcm_pkg::K_GLOBAL) ? {12'h000, rx_msg_in[7:0]} :
                               ((rx_kind == fcm_pkg::K_CLASS) | (rx_kind == fcm_pkg::K_UMAP) |
                                (rx_kind == fcm_pkg::K_MMAP)) ? {4'h0, rx_msg_in[15:0]} :
                               20'h00000;
  wire logic [3:0] rx_sp = !sub_en ? 4'h0 :
                           (rx_kind == fcm_pkg::K_MCAST) ? rx_msg_in[15:12] :
                           (rx_kind == fcm_pkg::K_CLASS) ? rx_msg_in[23:20] : 4'h0;
  wire logic rx_xon = rx_has_st ? (rx_st == fcm_pkg::ST_XON) : 1'b0;

  // link ready follows only clean messages; a parity error reads as not ready
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_ready_state_out <= 1'b0;
    end else if (rx_valid_in) begin
      link_ready_state_out <= rx_parity_ok_in & rx_msg_in[fcm_pkg::READY_BIT];
    end
  end

  // decoded message presented as a single-cycle pulse with its fields
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_dec_valid_out <= 1'b0;
      rx_dec_kind_out <= fcm_pkg::K_IDLE;
      rx_dec_group_out <= 8'h00;
      rx_dec_field_out <= 20'h00000;
      rx_dec_subport_out <= 4'h0;
      rx_dec_xon_out <= 1'b0;
      rx_dec_ready_out <= 1'b0;
      rx_dec_reserved_out <= 1'b0;
    end else begin
      rx_dec_valid_out <= rx_accept;
      if (rx_accept) begin
        rx_dec_kind_out <= rx_kind;
        rx_dec_group_out <= rx_group;
        rx_dec_field_out <= rx_field;
        rx_dec_subport_out <= rx_sp;
        rx_dec_xon_out <= rx_xon;
        rx_dec_ready_out <= rx_msg_in[fcm_pkg::READY_BIT];
        rx_dec_reserved_out <= rx_rsv;
      end
    end
  end

  // ----------------------------------------------------------------------
  // persistent class state, a unicast and a multicast bitmap per group, reset to XON
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 16; g++) begin : grp
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        uc_class[g] <= 16'hFFFF;
        mc_class[g] <= 16'hFFFF;
      end else begin
        if (uc_upd && rx_grp == 4'(g))
          uc_class[g] <= rx_msg_in[15:0];
        if (mc_upd && rx_grp == 4'(g))
          mc_class[g] <= rx_msg_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  ready_on_error_a: assert property (rx_valid_in && !rx_parity_ok_in |=>
    !link_ready_state_out && !rx_dec_valid_out) else $error("parity error kept ready");
  ready_follow_a: assert property (rx_accept |=>
    link_ready_state_out == $past(rx_msg_in[26]) && rx_dec_valid_out)
    else $error("ready bit not applied");
  idle_fill_a: assert property (slot_go && !cmd_pending && !(class_due && !qmap) |=>
    tx_valid_out && tx_msg_out[25:0] == 26'h3000000) else $error("idle not sent");
  quiet_training_a: assert property (training_in || loss_of_sync_alarm_in |=>
    !tx_valid_out) else $error("message during training");
  tx_ready_bit_a: assert property (tx_valid_out |->
    tx_msg_out[26] == $past(own_ready)) else $error("ready bit wrong");
  uni_status_a: assert property (tx_valid_out && !$past(egress) && !$past(qmap) &&
    tx_msg_out[25:24] == 2'h0 |-> tx_msg_out[3:0] == 4'hF || tx_msg_out[3:0] == 4'h0)
    else $error("reserved status sent");
  shared_m_a: assert property (tx_valid_out && $past(egress) && !$past(indep) |->
    !(tx_msg_out[25:24] == 2'h1)) else $error("multicast select set in shared mode");
  qmap_only_a: assert property (tx_valid_out && $past(qmap) |->
    tx_msg_out[25:24] != 2'h2) else $error("reserved type sent in queue map mode");
  global_low_a: assert property (tx_valid_out && !$past(egress) && !$past(qmap) &&
    tx_msg_out[25:23] == 3'h5 |-> (tx_msg_out[7:0] & ~GLOBAL_MASK) == 8'h00)
    else $error("global code low bits set");
  class_hold_a: assert property (rx_accept && rx_rsv |=>
    $stable(uc_class[rd_sel]) && $stable(mc_class[rd_sel])) else $error("reserved changed state");
  class_send_a: assert property (ctx_change && !qmap && !cmd_pending && !slot_go ##1
    slot_go && !cmd_pending && !qmap |=> tx_valid_out && tx_msg_out[15:0] == $past(class_tx[15:0],1))
    else $error("class change not sent");

endmodule

`default_nettype wire

/* File: test/status_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// status channel far end
// ----------------------------------------
module status_partner (
  input wire logic clock_in,
  input wire logic slot_en_in,
  input wire logic slow_in,
  output logic slot_out,
  output logic [26:0] rx_msg_out,
  output logic rx_valid_out,
  output logic rx_ok_out
);
  logic [1:0] div = 2'h0;
  initial begin
    slot_out = 1'b0;
    rx_msg_out = 27'h0;
    rx_valid_out = 1'b0;
    rx_ok_out = 1'b0;
  end
  // slow mode offers one slot in three, so pending work must wait its turn
  always @(posedge clock_in) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    slot_out <= slot_en_in && (!slow_in || div == 2'h0);
  end
  // whole message, ready in bit 26; released line shows the inverse, not the old value
  task automatic send(input logic [26:0] msg, input logic ok);
    @(posedge clock_in);
    rx_msg_out <= msg;
    rx_valid_out <= 1'b1;
    rx_ok_out <= ok;
    @(posedge clock_in);
    rx_msg_out <= ~msg;
    rx_valid_out <= 1'b0;
    rx_ok_out <= ~ok;
  endtask
endmodule
`default_nettype wire

/* File: test/fabric_flow_control_message_codec_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// codec bench: apb commands, tx slots, rx decode
// ----------------------------------------
module fabric_flow_control_message_codec_test;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slot_en = 1'b0, slow = 1'b0;
  logic training = 1'b0, alarm = 1'b0, exp_rdy = 1'b0, xon, err;
  logic [31:0] pwdata = 32'h0, prdata, rd, arg;
  logic pready, pslverr, slot, tx_valid, rx_valid, rx_ok, link_rdy, dvalid, dxon, drdy, drsv;
  logic [26:0] tx_msg, rx_msg, exp;
  logic [2:0] dkind;
  logic [7:0] dgrp;
  logic [19:0] dfld;
  logic [3:0] dsp;
  logic [15:0] map;
  integer seed = 32'hc854;
  int num_errors = 0, check_count = 0, cycles = 0;
  logic [26:0] tx_q[$];
  logic [37:0] dec_q[$];
  fabric_flow_control_message_codec #(.UC_ADDR_MASK(20'h0FFFF), .GLOBAL_BITS(5),
    .REFRESH_CYCLES(20)) fabric_flow_control_message_codec_i (.clock_in(clock_in),
    .rstn_in(rstn_in), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .tx_slot_in(slot), .training_in(training),
    .loss_of_sync_alarm_in(alarm), .tx_msg_out(tx_msg), .tx_valid_out(tx_valid),
    .rx_msg_in(rx_msg), .rx_valid_in(rx_valid), .rx_parity_ok_in(rx_ok),
    .link_ready_state_out(link_rdy), .rx_dec_valid_out(dvalid), .rx_dec_kind_out(dkind),
    .rx_dec_group_out(dgrp), .rx_dec_field_out(dfld), .rx_dec_subport_out(dsp),
    .rx_dec_xon_out(dxon), .rx_dec_ready_out(drdy), .rx_dec_reserved_out(drsv));
  status_partner status_partner_i (.clock_in(clock_in), .slot_en_in(slot_en),
    .slow_in(slow), .slot_out(slot), .rx_msg_out(rx_msg), .rx_valid_out(rx_valid),
    .rx_ok_out(rx_ok));
  always #5 clock_in = ~clock_in;
  task automatic check(input logic [37:0] got, input logic [37:0] want, input string what);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // request held until pready is seen high; no wait count is assumed
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_in);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // watcher: oldest note against each message that appears; idles checked in place
  always @(posedge clock_in) begin
    cycles++;
    if (tx_valid === 1'b1 && tx_msg[25:24] === fcm_pkg::TY_IDLE)
      check(tx_msg, {exp_rdy, fcm_pkg::IDLE_PAY}, "idle");
    else if (tx_valid === 1'b1)
      check(tx_msg, tx_q.size() ? tx_q.pop_front() : 27'h7FFFFFF, "tx");
    if (dvalid === 1'b1)
      check({dkind, dgrp, dfld, dsp, dxon, drdy, drsv},
        dec_q.size() ? dec_q.pop_front() : '1, "dec");
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    check({link_rdy, tx_valid, tx_msg}, {2'b00, 27'h3000000}, "reset");
    apb(fcm_pkg::OFF_CLASS_RD, 1'b0, 32'h0);
    check(rd, 32'hFFFFFFFF, "class reset");
    apb(8'h18, 1'b0, 32'h0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    slot_en <= 1'b1;
    repeat (10) @(posedge clock_in);
    slot_en <= 1'b0;
    repeat (3) @(posedge clock_in);
    apb(fcm_pkg::OFF_CTRL, 1'b1, 32'h00000310);
    exp_rdy <= 1'b1;
    slot_en <= 1'b1;
    slow <= 1'b1;
    // every standard kind; subport nonzero though disabled, so it must read zero
    for (int k = 0; k < 4; k++) begin
      arg = $random(seed);
      xon = arg[31];
      case (k)
        0: exp = {1'b1, 2'b00, arg[19:0] & 20'h0FFFF, {4{xon}}};
        1: exp = {1'b1, 2'b01, 4'h0, arg[19:0]};
        2: exp = {1'b1, 3'b100, 11'h0, arg[7:0], {4{xon}}};
        default: exp = {1'b1, 3'b101, 15'h0, arg[7:0] & 8'hF8};
      endcase
      tx_q.push_back(exp);
      apb(fcm_pkg::OFF_ARG, 1'b1, arg & 32'h00FFFFFF);
      apb(fcm_pkg::OFF_CMD, 1'b1, {23'h0, 1'b0, 4'hA, xon, k[2:0]});
      check(err, 1'b0, "cmd taken");
    end
    repeat (20) @(posedge clock_in);
    apb(fcm_pkg::OFF_CMD, 1'b1, 32'h00000004);
    check(err, 1'b1, "map kind in std mode");
    map = $random(seed);
    dec_q.push_back({3'h1, 8'h03, 4'h0, map, 4'h0, 1'b0, 1'b1, 1'b0});
    status_partner_i.send({1'b1, 2'b01, 4'h9, 4'h3, map}, 1'b1);
    repeat (2) @(posedge clock_in);
    check(link_rdy, 1'b1, "ready taken");
    apb(fcm_pkg::OFF_CLASS_RD, 1'b0, 32'h0);
    check(rd, {16'hFFFF, map}, "class kept");
    status_partner_i.send({1'b1, 2'b01, 4'h0, 4'h3, 16'h0}, 1'b0);
    repeat (2) @(posedge clock_in);
    check(link_rdy, 1'b0, "parity drop");
    // a clean unicast xon with its ready bit low
    dec_q.push_back({3'h0, 8'h00, 20'h12345, 4'h0, 1'b1, 1'b0, 1'b0});
    status_partner_i.send({1'b0, 2'b00, 20'h12345, 4'hF}, 1'b1);
    dec_q.push_back({3'h0, 8'h00, arg[19:0], 4'h0, 1'b0, 1'b1, 1'b1});
    status_partner_i.send({1'b1, 2'b00, arg[19:0], 4'h5}, 1'b1);
    repeat (2) @(posedge clock_in);
    check(link_rdy, 1'b1, "reserved ready");
    apb(fcm_pkg::OFF_CLASS_RD, 1'b0, 32'h0);
    check(rd, {16'hFFFF, map}, "reserved no change");
    // training and the alarm silence every slot
    training <= 1'b1;
    repeat (3) @(posedge clock_in);
    check(tx_valid, 1'b0, "training quiet");
    training <= 1'b0;
    alarm <= 1'b1;
    repeat (3) @(posedge clock_in);
    check(tx_valid, 1'b0, "alarm quiet");
    alarm <= 1'b0;
    // a changed class transmit word is announced without a command
    tx_q.push_back({1'b1, 2'b01, 4'h0, 20'h2A5C3});
    apb(fcm_pkg::OFF_CLASS_TX, 1'b1, 32'h0712A5C3);
    repeat (10) @(posedge clock_in);
    // egress with subport and independent multicast classes
    apb(fcm_pkg::OFF_CTRL, 1'b1, 32'h0000031D);
    arg = $random(seed);
    tx_q.push_back({1'b1, 2'b01, 4'hA, arg[19:0]});
    apb(fcm_pkg::OFF_ARG, 1'b1, arg & 32'h00FFFFFF);
    apb(fcm_pkg::OFF_CMD, 1'b1, 32'h000001A1);
    map = $random(seed);
    dec_q.push_back({3'h1, 8'h03, 4'h0, map, 4'h6, 1'b0, 1'b1, 1'b0});
    status_partner_i.send({1'b1, 2'b01, 4'h6, 4'h3, map}, 1'b1);
    apb(fcm_pkg::OFF_CLASS_RD, 1'b0, 32'h0);
    check(rd[31:16], map, "mcast class kept");
    repeat (10) @(posedge clock_in);
    // queue-map mode takes map kinds only and reserves type 10
    apb(fcm_pkg::OFF_CTRL, 1'b1, 32'h00000312);
    apb(fcm_pkg::OFF_CMD, 1'b1, 32'h00000000);
    check(err, 1'b1, "std kind in map mode");
    tx_q.push_back({1'b1, 2'b00, arg[23:0]});
    apb(fcm_pkg::OFF_CMD, 1'b1, 32'h00000004);
    dec_q.push_back({3'h7, 8'h00, 20'h0, 4'h0, 1'b0, 1'b1, 1'b1});
    status_partner_i.send({1'b1, 2'b10, 24'h0}, 1'b1);
    repeat (20) @(posedge clock_in);
    check(tx_q.size() + dec_q.size(), 0, "all seen");
    end_of_test();
  end
endmodule
`default_nettype wire
